// file: logical_xor_unit_map.svh
`ifndef LOGICAL_XOR_UNIT_MAP_SVH
`define LOGICAL_XOR_UNIT_MAP_SVH

// ****************************************************************
// Instruction fields (bit 0 of the word is the lsb)
// ****************************************************************
`define OPC_HI        31
`define OPC_LO        26
`define SRC_HI        25
`define SRC_LO        21
`define TGT_HI        20
`define TGT_LO        16
`define SEC_HI        15
`define SEC_LO        11
`define XO_HI         10
`define XO_LO         1
`define REC_BIT       0
`define IMM_HI        15
`define IMM_LO        0

`define OPC_EXT       6'h1f
`define OPC_XOR_LOW   6'h1a
`define OPC_XOR_HIGH  6'h1b
`define XO_XOR        10'h13c

// ****************************************************************
// Condition field layout
// ****************************************************************
`define CR_NEG        3
`define CR_POS        2
`define CR_ZERO       1
`define CR_OVF        0

// ****************************************************************
// Register map and reset values
// ****************************************************************
`define OFS_CONTROL   4'h0
`define OFS_COUNT     4'h4
`define OFS_LAST      4'h8
`define CONTROL_RST   1'b1
`define COUNT_RST     16'h0000
`define LAST_RST      32'h00000000

`endif

// file: logical_xor_pkg.sv
package logic_xor_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'b0001,
    OP_REG  = 4'b0010,
    OP_LOW  = 4'b0100,
    OP_HIGH = 4'b1000
  } op_e;

endpackage

// file: xor_decode.sv
`timescale 1ns/1ps
`include "logical_xor_unit_map.svh"

module xor_decode (
  input  wire logic [31:0]            instr_i,
  output logic_xor_pkg::op_e          op_o,
  output logic                        record_bit_o,
  output logic [4:0]                  target_register_field_o,
  output logic [15:0]                 unsigned_immediate_field_o
);

  logic [5:0] opcode;
  logic [9:0] ext_code;

  always_comb begin
    opcode                     = instr_i[`OPC_HI:`OPC_LO];
    ext_code                   = instr_i[`XO_HI:`XO_LO];
    target_register_field_o    = instr_i[`TGT_HI:`TGT_LO];
    unsigned_immediate_field_o = instr_i[`IMM_HI:`IMM_LO];
    record_bit_o               = 1'b0;
    op_o                       = logic_xor_pkg::OP_NONE;
    case (opcode)
      `OPC_EXT: begin
        if (ext_code == `XO_XOR) begin
          op_o         = logic_xor_pkg::OP_REG;
          record_bit_o = instr_i[`REC_BIT];
        end
      end
      `OPC_XOR_LOW: begin
        op_o = logic_xor_pkg::OP_LOW;
      end
      `OPC_XOR_HIGH: begin
        op_o = logic_xor_pkg::OP_HIGH;
      end
      default: begin
        op_o = logic_xor_pkg::OP_NONE;
      end
    endcase
  end

endmodule

// file: logical_xor_unit.sv
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "logical_xor_unit_map.svh"

module logical_xor_unit (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Issue side
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] source_value_i,
  input  wire logic [31:0] second_value_i,
  input  wire logic        summary_overflow_i,
  // Writeback side
  output logic             result_valid_o,
  output logic [31:0]      result_o,
  output logic [4:0]       target_index_o,
  output logic             cr0_write_o,
  output logic [3:0]       cr0_o,
  output logic             xer_write_o,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic_xor_pkg::op_e op;
  logic               record_bit;
  logic [4:0]         target_register_field;
  logic [15:0]        unsigned_immediate_field;

  xor_decode u_decode (
    .instr_i                    (instr_i),
    .op_o                       (op),
    .record_bit_o               (record_bit),
    .target_register_field_o    (target_register_field),
    .unsigned_immediate_field_o (unsigned_immediate_field)
  );

  // ****************************************************************
  // Execute
  // ****************************************************************
  logic        unit_enable;
  logic        issue_fire;
  logic [31:0] operand_b;
  logic [31:0] xor_value;
  logic [3:0]  flags;

  logic        next_result_valid;
  logic [31:0] next_result;
  logic [4:0]  next_target_index;
  logic        next_cr0_write;
  logic [3:0]  next_cr0;

  always_comb begin
    issue_fire = issue_valid_i && unit_enable && (op != logic_xor_pkg::OP_NONE);
    case (op)
      logic_xor_pkg::OP_REG:  operand_b = second_value_i;
      logic_xor_pkg::OP_LOW:  operand_b = {16'h0000, unsigned_immediate_field};
      logic_xor_pkg::OP_HIGH: operand_b = {unsigned_immediate_field, 16'h0000};
      default:                operand_b = 32'h00000000;
    endcase
    xor_value                = source_value_i ^ operand_b;
    flags[`CR_NEG]           = xor_value[31];
    flags[`CR_POS]           = !xor_value[31] && (xor_value != 32'h00000000);
    flags[`CR_ZERO]          = (xor_value == 32'h00000000);
    flags[`CR_OVF]           = summary_overflow_i;
    next_result_valid        = issue_fire;
    next_result              = issue_fire ? xor_value : result_o;
    next_target_index        = issue_fire ? target_register_field : target_index_o;
    // Only the record form touches the condition field
    next_cr0_write           = issue_fire && (op == logic_xor_pkg::OP_REG) && record_bit;
    next_cr0                 = next_cr0_write ? flags : cr0_o;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result_valid_o <= 1'b0;
      result_o       <= 32'h00000000;
      target_index_o <= 5'h00;
      cr0_write_o    <= 1'b0;
      cr0_o          <= 4'h0;
      xer_write_o    <= 1'b0;
    end else begin
      result_valid_o <= next_result_valid;
      result_o       <= next_result;
      target_index_o <= next_target_index;
      cr0_write_o    <= next_cr0_write;
      cr0_o          <= next_cr0;
      xer_write_o    <= 1'b0;
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [15:0] done_count;
  logic [31:0] last_result;
  logic        bus_req;
  logic        bus_take;
  logic        next_unit_enable;
  logic [15:0] next_done_count;
  logic [31:0] next_last_result;
  logic        next_waitrequest;
  logic [31:0] next_readdata;

  always_comb begin
    bus_req          = avs_read_i || avs_write_i;
    bus_take         = bus_req && !avs_waitrequest_o;
    next_waitrequest = !(bus_req && avs_waitrequest_o);
    next_unit_enable = unit_enable;
    if (bus_take && avs_write_i && (avs_address_i == `OFS_CONTROL) && avs_byteenable_i[0]) begin
      next_unit_enable = avs_writedata_i[0];
    end
    next_done_count  = result_valid_o ? done_count + 16'h0001 : done_count;
    next_last_result = result_valid_o ? result_o : last_result;
    next_readdata    = avs_readdata_o;
    if (avs_read_i && avs_waitrequest_o) begin
      case (avs_address_i)
        `OFS_CONTROL: next_readdata = {31'h00000000, unit_enable};
        `OFS_COUNT:   next_readdata = {16'h0000, done_count};
        `OFS_LAST:    next_readdata = last_result;
        default:      next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unit_enable       <= `CONTROL_RST;
      done_count        <= `COUNT_RST;
      last_result       <= `LAST_RST;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      unit_enable       <= next_unit_enable;
      done_count        <= next_done_count;
      last_result       <= next_last_result;
      avs_waitrequest_o <= next_waitrequest;
      avs_readdata_o    <= next_readdata;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_fire_reg_rec;
    issue_fire && (op == logic_xor_pkg::OP_REG) && record_bit;
  endsequence

  sequence s_fire_reg_plain;
    issue_fire && (op == logic_xor_pkg::OP_REG) && !record_bit;
  endsequence

  sequence s_fire_low;
    issue_fire && (op == logic_xor_pkg::OP_LOW);
  endsequence

  sequence s_fire_high;
    issue_fire && (op == logic_xor_pkg::OP_HIGH);
  endsequence

  chk_record_cr0_update: assert property (
    s_fire_reg_rec |=> cr0_write_o && result_valid_o
                       && (cr0_o[`CR_OVF] == $past(summary_overflow_i)))
    else $error("record form did not update condition field");

  chk_plain_cr0_hold: assert property (
    s_fire_reg_plain |=> !cr0_write_o && $stable(cr0_o))
    else $error("plain form changed condition field");

  chk_xer_never_written: assert property (
    result_valid_o |-> !xer_write_o)
    else $error("exception register written");

  chk_reg_xor_result: assert property (
    s_fire_reg_rec or s_fire_reg_plain |=> result_valid_o
      && (result_o == ($past(source_value_i) ^ $past(second_value_i)))
      && (target_index_o == $past(instr_i[`TGT_HI:`TGT_LO])))
    else $error("register form result wrong");

  chk_low_xor_result: assert property (
    s_fire_low |=> result_o == ($past(source_value_i) ^ {16'h0000, $past(instr_i[15:0])}))
    else $error("low immediate result wrong");

  chk_low_no_flags: assert property (
    s_fire_low |=> !cr0_write_o && !xer_write_o && $stable(cr0_o))
    else $error("low immediate touched flags");

  chk_low_opcode_decode: assert property (
    issue_valid_i && unit_enable && (instr_i[`OPC_HI:`OPC_LO] == `OPC_XOR_LOW)
      |=> result_valid_o && (target_index_o == $past(instr_i[20:16])))
    else $error("opcode 26 not executed");

  chk_high_xor_result: assert property (
    s_fire_high |=> result_o == ($past(source_value_i) ^ {$past(instr_i[15:0]), 16'h0000}))
    else $error("high immediate result wrong");

  chk_high_no_flags: assert property (
    s_fire_high |=> !cr0_write_o && !xer_write_o && $stable(cr0_o))
    else $error("high immediate touched flags");

  chk_high_opcode_decode: assert property (
    issue_valid_i && unit_enable && (instr_i[`OPC_HI:`OPC_LO] == `OPC_XOR_HIGH)
      |=> result_valid_o && !cr0_write_o)
    else $error("opcode 27 not executed");

  chk_flag_from_sign: assert property (
    cr0_write_o |-> (cr0_o[`CR_NEG] == result_o[31])
      && (cr0_o[`CR_ZERO] == (result_o == 32'h00000000))
      && (cr0_o[`CR_POS] == (!result_o[31] && (result_o != 32'h00000000))))
    else $error("condition flags disagree with result");

  chk_bus_answer_time: assert property (
    bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not in one cycle");

endmodule

// file: operand_stage.sv
`timescale 1ns/1ps
`include "logical_xor_unit_map.svh"

// ****************************************************************
// Register read stage with writeback into a small register file
// ****************************************************************
module operand_stage (
  input  wire logic        clk_i,
  input  wire logic        load_i,
  input  wire logic [4:0]  load_index_i,
  input  wire logic [31:0] load_value_i,
  input  wire logic [31:0] instr_i,
  input  wire logic        result_valid_i,
  input  wire logic [4:0]  target_index_i,
  input  wire logic [31:0] result_i,
  output logic      [31:0] source_value_o,
  output logic      [31:0] second_value_o
);
  logic [31:0] gpr [32];

  always @(posedge clk_i) begin
    if (load_i) begin
      gpr[load_index_i] <= load_value_i;
    end else if (result_valid_i) begin
      gpr[target_index_i] <= result_i;
    end
  end

  assign source_value_o = gpr[instr_i[`SRC_HI:`SRC_LO]];
  assign second_value_o = gpr[instr_i[`SEC_HI:`SEC_LO]];
endmodule

// file: testbench.sv
`timescale 1ns/1ps

module testbench;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        issue_valid_i = 1'b0;
  logic        summary_overflow_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  logic [31:0] source_value_i, second_value_i, result_o, avs_readdata_o, q;
  logic [4:0]  target_index_o;
  logic [3:0]  cr0_o;
  logic        result_valid_o, cr0_write_o, xer_write_o, avs_waitrequest_o;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic        load_i = 1'b0;
  logic [4:0]  load_index_i = 5'h0;
  logic [31:0] load_value_i = 32'h0;
  logic        got_v, got_c, got_x;
  int          mismatches = 0;
  int          checked = 0;

  always #50 clk_i = ~clk_i;

  logical_xor_unit DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .issue_valid_i(issue_valid_i),
    .instr_i(instr_i), .source_value_i(source_value_i), .second_value_i(second_value_i),
    .summary_overflow_i(summary_overflow_i), .result_valid_o(result_valid_o),
    .result_o(result_o), .target_index_o(target_index_o), .cr0_write_o(cr0_write_o),
    .cr0_o(cr0_o), .xer_write_o(xer_write_o), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o));

  operand_stage partner (.clk_i(clk_i), .load_i(load_i), .load_index_i(load_index_i),
    .load_value_i(load_value_i), .instr_i(instr_i), .result_valid_i(result_valid_o),
    .target_index_i(target_index_o), .result_i(result_o), .source_value_o(source_value_i),
    .second_value_o(second_value_i));

  // ****************************************************************
  // Access tasks and comparisons
  // ****************************************************************
  function automatic logic [31:0] enc_x(logic [4:0] s, t, b, logic rc, logic [9:0] xo);
    return {6'h1f, s, t, b, xo, rc};
  endfunction

  function automatic logic [31:0] enc_i(logic [5:0] op, logic [4:0] s, t, logic [15:0] ui);
    return {op, s, t, ui};
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic load(input logic [4:0] i, input logic [31:0] v);
    @(posedge clk_i);
    load_i <= 1'b1;
    load_index_i <= i;
    load_value_i <= v;
    @(posedge clk_i);
    load_i <= 1'b0;
  endtask

  task automatic issue(input logic [31:0] w, input logic so);
    @(posedge clk_i);
    issue_valid_i <= 1'b1;
    instr_i <= w;
    summary_overflow_i <= so;
    @(posedge clk_i);
    issue_valid_i <= 1'b0;
    #1;
    got_v = result_valid_o;
    got_c = cr0_write_o;
    got_x = xer_write_o;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    if (wr) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic results();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  logic [4:0]  ri [6] = '{5'd4, 5'd5, 5'd7, 5'd9, 5'd10, 5'd11};
  logic [31:0] rv [6] = '{32'h90003000, 32'hb0043000, 32'h789a789b, 32'h90000000,
                          32'h7b4192c0, 32'h00000000};
  logic [4:0]  cs [4] = '{5'd5, 5'd4, 5'd11, 5'd4};
  logic [4:0]  cb [4] = '{5'd7, 5'd9, 5'd11, 5'd4};
  logic        co [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [31:0] cr [4] = '{32'hc89e489b, 32'h00003000, 32'h0, 32'h0};
  logic [3:0]  cf [4] = '{4'h9, 4'h4, 4'h2, 4'h3};
  logic [5:0]  io [4] = '{6'h1a, 6'h1a, 6'h1b, 6'h1b};
  logic [4:0]  is [4] = '{5'd10, 5'd4, 5'd4, 5'd10};
  logic [15:0] iu [4] = '{16'h5730, 16'hffff, 16'h0079, 16'h8000};
  logic [31:0] ir [4] = '{32'h7b41c5f0, 32'h9000cfff, 32'h90793000, 32'hfb4192c0};

  initial begin
    #(100 * 3000);
    mismatches++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    check_word(q, 32'h1);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    check_word(q, 32'h0);
    for (int i = 0; i < 6; i++) load(ri[i], rv[i]);
    issue(enc_x(5'd4, 5'd6, 5'd7, 1'b0, 10'h13c), 1'b1);
    check_bit(got_v, 1'b1);
    check_word(result_o, 32'he89a489b);
    check_word({27'h0, target_index_o}, 32'h6);
    check_bit(got_c, 1'b0);
    check_bit(got_x, 1'b0);
    for (int i = 0; i < 4; i++) begin
      issue(enc_x(cs[i], 5'd12, cb[i], 1'b1, 10'h13c), co[i]);
      check_word(result_o, cr[i]);
      check_bit(got_c, 1'b1);
      check_word({28'h0, cr0_o}, {28'h0, cf[i]});
      check_bit(got_x, 1'b0);
    end
    issue(enc_x(5'd4, 5'd12, 5'd7, 1'b0, 10'h13c), 1'b0);
    check_bit(got_c, 1'b0);
    check_word({28'h0, cr0_o}, 32'h3);
    for (int i = 0; i < 4; i++) begin
      issue(enc_i(io[i], is[i], 5'd14, iu[i]), 1'b1);
      check_bit(got_v, 1'b1);
      check_word(result_o, ir[i]);
      check_word({27'h0, target_index_o}, 32'he);
      check_bit(got_c, 1'b0);
      check_bit(got_x, 1'b0);
      check_word({28'h0, cr0_o}, 32'h3);
    end
    // Operand comes back through the partner's writeback path
    issue(enc_x(5'd6, 5'd13, 5'd7, 1'b0, 10'h13c), 1'b0);
    check_word(result_o, 32'h90003000);
    issue(enc_i(6'h18, 5'd4, 5'd5, 16'h1), 1'b0);
    check_bit(got_v, 1'b0);
    issue(enc_x(5'd4, 5'd6, 5'd7, 1'b1, 10'h13b), 1'b0);
    check_bit(got_v, 1'b0);
    bus(1'b1, 4'h0, 32'h0, 4'h0);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    check_word(q, 32'h1);
    bus(1'b1, 4'h0, 32'h0, 4'h1);
    issue(enc_i(6'h1a, 5'd4, 5'd5, 16'h1), 1'b0);
    check_bit(got_v, 1'b0);
    bus(1'b1, 4'h0, 32'h1, 4'hf);
    bus(1'b1, 4'h4, 32'h0, 4'hf);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    check_word(q, 32'd11);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    check_word(q, 32'h90003000);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    check_word(q, 32'h0);
    results();
  end
endmodule
